// file: logic/sse_dec3.sv
// Purpose: Byte to three ASCII decimal digits
// Assumes: Value 0..255
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.svh"
module sse_dec3 (
  input  wire logic [7:0] value,
  output logic      [7:0] hundredsChar,
  output logic      [7:0] tensChar,
  output logic      [7:0] onesChar
);
  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  // Division by constants is cheap at eight bits
  assign hundredsChar = `SSE_ASCII_ZERO + 8'(value / 8'h64);
  assign tensChar     = `SSE_ASCII_ZERO + 8'((value / 8'h0a) % 8'h0a);
  assign onesChar     = `SSE_ASCII_ZERO + 8'(value % 8'h0a);
endmodule
`default_nettype wire

// file: logic/sse_defines.svh
// Purpose: Constants of the supply status and event register bank
// Assumes: Included by bare name wherever the bank's constants are needed
// Notes:   Holds definitions only
//
// Functional notes
// - Condition A bit 7 high while the sequence runs or is held.
// - Condition A bit 1 shows current regulation, bit 0 voltage regulation.
// - Condition A bits 6..2: trigger, overtemp, overvoltage, signal output, overload.
// - Event A bit 7 set when the sequence completes and goes inactive.
// - Event A bit 6 set on overtemp recovery, bit 5 on overtemp.
// - Event A bits 4,3,2 set on overvoltage, overcurrent and overload.
// - Event A bits 1,0 record that current or voltage regulation occurred.
// - Event B bit 7 on self-test or adjust error, bit 6 on trigger.
// - Event B bit 5 set on a sequence error.
// - Event B bit 4 set when output-on fails due to trigger disable.
// - Event B bit 3 set on a device trigger definition error.
// - Event B bit 1 on signal output two active, bit 0 on one.
// - Event A enable mask is readable as three decimal digits.
// - Event B enable mask is readable as three decimal digits.
// - Standard event enable mask and standard event register are readable.
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH

// ----------------------------------------------------------------
// Query selector codes
// ----------------------------------------------------------------
`define SSE_SEL_COND_A     3'h0
`define SSE_SEL_EVENTS_A   3'h1
`define SSE_SEL_MASK_A     3'h2
`define SSE_SEL_EVENTS_B   3'h3
`define SSE_SEL_MASK_B     3'h4
`define SSE_SEL_STD_MASK   3'h5
`define SSE_SEL_STD_STATUS 3'h6

// ----------------------------------------------------------------
// Bit positions, shared by both event registers and condition A
// ----------------------------------------------------------------
`define SSE_BIT_D7 7
`define SSE_BIT_D6 6
`define SSE_BIT_D5 5
`define SSE_BIT_D4 4
`define SSE_BIT_D3 3
`define SSE_BIT_D2 2
`define SSE_BIT_D1 1
`define SSE_BIT_D0 0

// ----------------------------------------------------------------
// Reset values and reply format
// ----------------------------------------------------------------
`define SSE_RESET_REG   8'h00
`define SSE_ASCII_ZERO  8'h30
`define SSE_REPLY_CHARS 2'h3

`endif

// file: logic/sse_pkg.sv
// Purpose: Types of the supply status and event register bank
// Assumes: Nothing
// Notes:   Constants live in sse_defines.svh
`default_nettype none
package sse_pkg;
  typedef enum logic {
    SSE_IDLE,
    SSE_EMIT
  } sse_state_e;
  typedef logic [7:0] sse_byte_t;
endpackage
`default_nettype wire

// file: logic/sse_status_bank.sv
// Purpose: Condition, event and mask registers with decimal query replies
// Assumes: All status inputs come from logic on the same clock
// Notes:   One query at a time; queries while busy are ignored
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.svh"
module sse_status_bank #(
  parameter int LIMIT_W = 16
) (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               queryStrobe,
  input  wire logic [2:0]         querySelect,
  input  wire logic               maskWrite,
  input  wire logic [2:0]         maskSelect,
  input  wire logic [7:0]         maskData,
  input  wire logic               sequenceRunning,
  input  wire logic               analogTriggerSeen,
  input  wire logic               overtempFlag,
  input  wire logic               overvoltageTrip,
  input  wire logic               overcurrentTrip,
  input  wire logic               overloadState,
  input  wire logic               currentRegState,
  input  wire logic               voltageRegState,
  input  wire logic               signalOutputOne,
  input  wire logic               signalOutputTwo,
  input  wire logic               selftestOrAdjustError,
  input  wire logic               sequenceError,
  input  wire logic               outputEnableError,
  input  wire logic               deviceTriggerDefError,
  input  wire logic [LIMIT_W-1:0] voltageSetpoint,
  input  wire logic [LIMIT_W-1:0] currentSetpoint,
  input  wire logic [LIMIT_W-1:0] voltageLimit,
  input  wire logic [LIMIT_W-1:0] currentLimit,
  input  wire logic [7:0]         stdEventStatus,
  output logic                    queryBusy,
  output logic                    replyValid,
  output logic                    replyLast,
  output logic      [7:0]         replyChar,
  output logic                    eventsASummary,
  output logic                    eventsBSummary
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sse_pkg::sse_state_e state;
  sse_pkg::sse_byte_t  liveConditionA;
  sse_pkg::sse_byte_t  latchedEventsA;
  sse_pkg::sse_byte_t  latchedEventsB;
  sse_pkg::sse_byte_t  eventsAMask;
  sse_pkg::sse_byte_t  eventsBMask;
  sse_pkg::sse_byte_t  stdEventMask;
  sse_pkg::sse_byte_t  snapshot;
  sse_pkg::sse_byte_t  setA;
  sse_pkg::sse_byte_t  setB;
  sse_pkg::sse_byte_t  selected;
  logic [1:0]          charIndex;
  logic [7:0]          hundredsChar;
  logic [7:0]          tensChar;
  logic [7:0]          onesChar;
  logic                queryTake;
  logic                clearA;
  logic                clearB;
  logic                limitError;
  // Previous samples for edge detection
  logic prevSeq;
  logic prevTrig;
  logic prevTemp;
  logic prevOvp;
  logic prevOcp;
  logic prevOvl;
  logic prevCcr;
  logic prevCvr;
  logic prevSig1;
  logic prevSig2;
  logic prevTce;
  logic prevSeqErr;
  logic prevOutErr;
  logic prevDdtErr;
  logic prevLimErr;

  // ----------------------------------------------------------------
  // Live condition
  // ----------------------------------------------------------------
  assign liveConditionA = {sequenceRunning,
                           analogTriggerSeen,
                           overtempFlag,
                           overvoltageTrip,
                           signalOutputOne | signalOutputTwo,
                           overloadState,
                           currentRegState,
                           voltageRegState};

  assign limitError = (voltageLimit < voltageSetpoint) ||
                      (currentLimit < currentSetpoint);

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {prevSeq, prevTrig, prevTemp, prevOvp, prevOcp} <= 5'h00;
      {prevOvl, prevCcr, prevCvr, prevSig1, prevSig2} <= 5'h00;
      {prevTce, prevSeqErr, prevOutErr, prevDdtErr, prevLimErr} <= 5'h00;
    end else begin
      {prevSeq, prevTrig, prevTemp, prevOvp, prevOcp} <=
        {sequenceRunning, analogTriggerSeen, overtempFlag, overvoltageTrip, overcurrentTrip};
      {prevOvl, prevCcr, prevCvr, prevSig1, prevSig2} <=
        {overloadState, currentRegState, voltageRegState, signalOutputOne, signalOutputTwo};
      {prevTce, prevSeqErr, prevOutErr, prevDdtErr, prevLimErr} <=
        {selftestOrAdjustError, sequenceError, outputEnableError, deviceTriggerDefError,
         limitError};
    end
  end

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  always_comb begin
    setA = `SSE_RESET_REG;
    setB = `SSE_RESET_REG;
    setA[`SSE_BIT_D7] = prevSeq & ~sequenceRunning;
    setA[`SSE_BIT_D6] = prevTemp & ~overtempFlag;
    setA[`SSE_BIT_D5] = ~prevTemp & overtempFlag;
    setA[`SSE_BIT_D4] = ~prevOvp & overvoltageTrip;
    setA[`SSE_BIT_D3] = ~prevOcp & overcurrentTrip;
    setA[`SSE_BIT_D2] = ~prevOvl & overloadState;
    setA[`SSE_BIT_D1] = ~prevCcr & currentRegState;
    setA[`SSE_BIT_D0] = ~prevCvr & voltageRegState;
    setB[`SSE_BIT_D7] = ~prevTce & selftestOrAdjustError;
    setB[`SSE_BIT_D6] = ~prevTrig & analogTriggerSeen;
    setB[`SSE_BIT_D5] = ~prevSeqErr & sequenceError;
    setB[`SSE_BIT_D4] = ~prevOutErr & outputEnableError;
    setB[`SSE_BIT_D3] = ~prevDdtErr & deviceTriggerDefError;
    setB[`SSE_BIT_D2] = ~prevLimErr & limitError;
    setB[`SSE_BIT_D1] = ~prevSig2 & signalOutputTwo;
    setB[`SSE_BIT_D0] = ~prevSig1 & signalOutputOne;
  end

  // ----------------------------------------------------------------
  // Latched events, cleared by their own read
  // ----------------------------------------------------------------
  assign queryTake = queryStrobe && (state == sse_pkg::SSE_IDLE);
  assign clearA    = queryTake && (querySelect == `SSE_SEL_EVENTS_A);
  assign clearB    = queryTake && (querySelect == `SSE_SEL_EVENTS_B);

  // Set wins over the read clear so no event is lost
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latchedEventsA <= `SSE_RESET_REG;
      latchedEventsB <= `SSE_RESET_REG;
    end else begin
      latchedEventsA <= (clearA ? `SSE_RESET_REG : latchedEventsA) | setA;
      latchedEventsB <= (clearB ? `SSE_RESET_REG : latchedEventsB) | setB;
    end
  end

  // ----------------------------------------------------------------
  // Enable masks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eventsAMask  <= `SSE_RESET_REG;
      eventsBMask  <= `SSE_RESET_REG;
      stdEventMask <= `SSE_RESET_REG;
    end else if (maskWrite) begin
      case (maskSelect)
        `SSE_SEL_MASK_A:   eventsAMask  <= maskData;
        `SSE_SEL_MASK_B:   eventsBMask  <= maskData;
        `SSE_SEL_STD_MASK: stdEventMask <= maskData;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Summary bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eventsASummary <= 1'b0;
      eventsBSummary <= 1'b0;
    end else begin
      eventsASummary <= |(latchedEventsA & eventsAMask);
      eventsBSummary <= |(latchedEventsB & eventsBMask);
    end
  end

  // ----------------------------------------------------------------
  // Query reply
  // ----------------------------------------------------------------
  always_comb begin
    case (querySelect)
      `SSE_SEL_COND_A:     selected = liveConditionA;
      `SSE_SEL_EVENTS_A:   selected = latchedEventsA;
      `SSE_SEL_MASK_A:     selected = eventsAMask;
      `SSE_SEL_EVENTS_B:   selected = latchedEventsB;
      `SSE_SEL_MASK_B:     selected = eventsBMask;
      `SSE_SEL_STD_MASK:   selected = stdEventMask;
      `SSE_SEL_STD_STATUS: selected = stdEventStatus;
      default:             selected = `SSE_RESET_REG;
    endcase
  end

  sse_dec3 u_dec3 (
    .value        (snapshot),
    .hundredsChar (hundredsChar),
    .tensChar     (tensChar),
    .onesChar     (onesChar)
  );

  // Snapshot keeps the reply stable while events keep arriving
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      snapshot <= `SSE_RESET_REG;
    end else if (queryTake) begin
      snapshot <= selected;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state      <= sse_pkg::SSE_IDLE;
      charIndex  <= 2'h0;
      queryBusy  <= 1'b0;
      replyValid <= 1'b0;
      replyLast  <= 1'b0;
      replyChar  <= `SSE_RESET_REG;
    end else begin
      case (state)
        sse_pkg::SSE_IDLE: begin
          replyValid <= 1'b0;
          replyLast  <= 1'b0;
          charIndex  <= 2'h0;
          if (queryTake) begin
            state     <= sse_pkg::SSE_EMIT;
            queryBusy <= 1'b1;
          end
        end
        sse_pkg::SSE_EMIT: begin
          replyValid <= 1'b1;
          charIndex  <= charIndex + 2'h1;
          case (charIndex)
            2'h0:    replyChar <= hundredsChar;
            2'h1:    replyChar <= tensChar;
            default: replyChar <= onesChar;
          endcase
          if (charIndex == `SSE_REPLY_CHARS - 2'h1) begin
            replyLast <= 1'b1;
            queryBusy <= 1'b0;
            state     <= sse_pkg::SSE_IDLE;
          end
        end
        default: begin
          state     <= sse_pkg::SSE_IDLE;
          queryBusy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_threeChars;
    replyValid [*3] ##1 !replyValid;
  endsequence

  property p_replyThree;
    @(posedge clock) disable iff (!rst_b)
      queryTake ##1 1'b1 |=> s_threeChars;
  endproperty
  a_replyThree: assert property (p_replyThree) else $error("reply not three chars");

  property p_replyValue;
    @(posedge clock) disable iff (!rst_b)
      queryTake ##1 1'b1 |=> (replyChar == hundredsChar) ##1 (replyChar == tensChar)
                             ##1 (replyChar == onesChar && replyLast);
  endproperty
  a_replyValue: assert property (p_replyValue) else $error("reply digits wrong");

  property p_condSeq;
    @(posedge clock) disable iff (!rst_b)
      queryTake && querySelect == `SSE_SEL_COND_A |=> snapshot[7] == $past(sequenceRunning);
  endproperty
  a_condSeq: assert property (p_condSeq) else $error("cond bit7 wrong");

  property p_condReg;
    @(posedge clock) disable iff (!rst_b)
      queryTake && querySelect == `SSE_SEL_COND_A
        |=> snapshot[1:0] == {$past(currentRegState), $past(voltageRegState)};
  endproperty
  a_condReg: assert property (p_condReg) else $error("cond reg mode wrong");

  property p_condLive;
    @(posedge clock) disable iff (!rst_b)
      queryTake && querySelect == `SSE_SEL_COND_A
        |=> snapshot[3] == ($past(signalOutputOne) | $past(signalOutputTwo));
  endproperty
  a_condLive: assert property (p_condLive) else $error("cond bit3 wrong");

  property p_seqDone;
    @(posedge clock) disable iff (!rst_b)
      $fell(sequenceRunning) |=> latchedEventsA[7];
  endproperty
  a_seqDone: assert property (p_seqDone) else $error("seq done lost");

  property p_tempRecover;
    @(posedge clock) disable iff (!rst_b)
      $fell(overtempFlag) |=> latchedEventsA[6] && !$past(setA[5]);
  endproperty
  a_tempRecover: assert property (p_tempRecover) else $error("recovery lost");

  property p_ocp;
    @(posedge clock) disable iff (!rst_b)
      $rose(overcurrentTrip) |=> latchedEventsA[3];
  endproperty
  a_ocp: assert property (p_ocp) else $error("ocp lost");

  property p_ccr;
    @(posedge clock) disable iff (!rst_b)
      $rose(currentRegState) |=> latchedEventsA[1];
  endproperty
  a_ccr: assert property (p_ccr) else $error("ccr lost");

  property p_trigB;
    @(posedge clock) disable iff (!rst_b)
      $rose(analogTriggerSeen) |=> latchedEventsB[6];
  endproperty
  a_trigB: assert property (p_trigB) else $error("trigger lost");

  property p_limit;
    @(posedge clock) disable iff (!rst_b)
      $rose(limitError) |=> latchedEventsB[2];
  endproperty
  a_limit: assert property (p_limit) else $error("limit lost");

  property p_sigTwo;
    @(posedge clock) disable iff (!rst_b)
      $rose(signalOutputTwo) |=> latchedEventsB[1];
  endproperty
  a_sigTwo: assert property (p_sigTwo) else $error("sig two lost");

  property p_clearRead;
    @(posedge clock) disable iff (!rst_b)
      clearA && setA == `SSE_RESET_REG |=> latchedEventsA == `SSE_RESET_REG;
  endproperty
  a_clearRead: assert property (p_clearRead) else $error("read did not clear");

  property p_summaryA;
    @(posedge clock) disable iff (!rst_b)
      ##1 eventsASummary == |($past(latchedEventsA) & $past(eventsAMask));
  endproperty
  a_summaryA: assert property (p_summaryA) else $error("summary A wrong");

  property p_maskA;
    @(posedge clock) disable iff (!rst_b)
      queryTake && querySelect == `SSE_SEL_MASK_A |=> snapshot == $past(eventsAMask);
  endproperty
  a_maskA: assert property (p_maskA) else $error("mask A reply wrong");
endmodule
`default_nettype wire

// file: test/sse_host_model.sv
// Purpose: Host side of the query link: asks one register, decodes the digits
// Assumes: Called only while the bank is idle
// Notes:   Select is scrambled after the take edge to expose late sampling
`timescale 1ns/1ps
`default_nettype none
module sse_host_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       queryBusy,
  input  wire logic       replyValid,
  input  wire logic       replyLast,
  input  wire logic [7:0] replyChar,
  output logic            queryStrobe,
  output logic      [2:0] querySelect
);
  initial begin
    queryStrobe = 1'b0;
    querySelect = 3'h7;
  end
  // ------------------------------------------------------------
  // One query, digits gathered at the falling edge
  // ------------------------------------------------------------
  task automatic query(input logic [2:0] sel, output logic [7:0] val, output int nChar,
                       output logic lastOk, output logic sawBusy);
    int waitCnt;
    int acc;
    acc = 0;
    nChar = 0;
    lastOk = 1'b0;
    sawBusy = 1'b0;
    waitCnt = 0;
    @(posedge clock);
    queryStrobe <= 1'b1;
    querySelect <= sel;
    @(posedge clock);
    queryStrobe <= 1'b0;
    querySelect <= ~sel;
    while (!lastOk && waitCnt < 12) begin
      @(negedge clock);
      waitCnt++;
      if (queryBusy === 1'b1) sawBusy = 1'b1;
      if (replyValid === 1'b1) begin
        nChar++;
        if (replyChar < 8'h30 || replyChar > 8'h39) acc = 999;
        else acc = acc * 10 + int'(replyChar - 8'h30);
        if (replyLast === 1'b1) lastOk = (nChar == 3);
      end
    end
    val = (acc > 255) ? 8'hxx : acc[7:0];
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Purpose: Self-checking bench of the status and event register bank
// Assumes: Host model issues every query
// Notes:   Status inputs packed in one vector to keep stimulus short
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [13:0] statusIn = 14'h0000;
  logic [15:0] vSet = 16'h0000;
  logic [15:0] vLim = 16'h0000;
  logic [15:0] current_setpoint = 16'h0000;
  logic [15:0] iLim = 16'h0000;
  logic        maskWrite = 1'b0;
  logic [2:0]  maskSelect = 3'h0;
  logic [7:0]  maskData = 8'h00;
  logic [7:0]  stdStatus = 8'h00;
  logic        queryStrobe;
  logic [2:0]  querySelect;
  logic        queryBusy;
  logic        replyValid;
  logic        replyLast;
  logic [7:0]  replyChar;
  logic        sumA;
  logic        sumB;
  int          fails = 0;
  int          nChecks = 0;
  int          cycles = 0;

  always #2 clock = ~clock;

  sse_status_bank #(.LIMIT_W(16)) dut_u (
    .clock(clock), .rst_b(rst_b), .queryStrobe(queryStrobe), .querySelect(querySelect),
    .maskWrite(maskWrite), .maskSelect(maskSelect), .maskData(maskData),
    .sequenceRunning(statusIn[13]), .analogTriggerSeen(statusIn[12]),
    .overtempFlag(statusIn[11]), .overvoltageTrip(statusIn[10]),
    .overcurrentTrip(statusIn[9]), .overloadState(statusIn[8]),
    .currentRegState(statusIn[7]), .voltageRegState(statusIn[6]),
    .signalOutputOne(statusIn[5]), .signalOutputTwo(statusIn[4]),
    .selftestOrAdjustError(statusIn[3]), .sequenceError(statusIn[2]),
    .outputEnableError(statusIn[1]), .deviceTriggerDefError(statusIn[0]),
    .voltageSetpoint(vSet), .currentSetpoint(current_setpoint), .voltageLimit(vLim),
    .currentLimit(iLim), .stdEventStatus(stdStatus), .queryBusy(queryBusy),
    .replyValid(replyValid), .replyLast(replyLast), .replyChar(replyChar),
    .eventsASummary(sumA), .eventsBSummary(sumB));

  sse_host_model host_u (
    .clock(clock), .rst_b(rst_b), .queryBusy(queryBusy), .replyValid(replyValid),
    .replyLast(replyLast), .replyChar(replyChar), .queryStrobe(queryStrobe),
    .querySelect(querySelect));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    nChecks++;
    if (seen !== expd) begin
      fails++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic ask(input logic [2:0] sel, input logic [7:0] expd);
    logic [7:0] v;
    int         n;
    logic       lastOk;
    logic       busy;
    host_u.query(sel, v, n, lastOk, busy);
    check(v, expd);
    check({7'h00, lastOk & busy}, 8'h01);
    check(n[7:0], 8'h03);
  endtask

  // Settle time covers event latch plus summary lag
  task automatic drive(input logic [13:0] v);
    @(posedge clock);
    statusIn <= v;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic setMask(input logic [2:0] sel, input logic [7:0] d);
    @(posedge clock);
    maskWrite <= 1'b1;
    maskSelect <= sel;
    maskData <= d;
    @(posedge clock);
    maskWrite <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    for (int s = 0; s < 8; s++) ask(s[2:0], 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_condition;
    drive(14'h28a0);
    ask(3'h0, 8'haa);
    drive(14'h1550);
    ask(3'h0, 8'h5d);
    drive(14'h0030);
    ask(3'h0, 8'h08);
    drive(14'h0000);
    ask(3'h0, 8'h00);
    ask(3'h1, 8'hf7);
    ask(3'h3, 8'h43);
    $display("test_condition done");
  endtask

  task automatic test_events;
    @(posedge clock);
    vSet <= 16'h0100;
    drive(14'h020f);
    drive(14'h0000);
    ask(3'h1, 8'h08);
    ask(3'h3, 8'hbc);
    ask(3'h1, 8'h00);
    ask(3'h3, 8'h00);
    drive(14'h0800);
    drive(14'h0000);
    ask(3'h1, 8'h60);
    @(posedge clock);
    vLim <= 16'h0200;
    drive(14'h0000);
    ask(3'h3, 8'h00);
    @(posedge clock);
    current_setpoint <= 16'h0010;
    drive(14'h0000);
    ask(3'h3, 8'h04);
    $display("test_events done");
  endtask

  task automatic test_masks;
    setMask(3'h2, 8'h20);
    setMask(3'h4, 8'h80);
    setMask(3'h5, 8'h90);
    setMask(3'h1, 8'hff);
    stdStatus <= 8'h90;
    ask(3'h2, 8'h20);
    ask(3'h4, 8'h80);
    ask(3'h5, 8'h90);
    ask(3'h6, 8'h90);
    drive(14'h0100);
    check({6'h00, sumA, sumB}, 8'h00);
    drive(14'h0908);
    check({6'h00, sumA, sumB}, 8'h03);
    ask(3'h1, 8'h24);
    repeat (2) @(negedge clock);
    check({6'h00, sumA, sumB}, 8'h01);
    setMask(3'h4, 8'h00);
    repeat (3) @(negedge clock);
    check({6'h00, sumA, sumB}, 8'h00);
    drive(14'h0000);
    $display("test_masks done");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    test_reset();
    test_condition();
    test_events();
    test_masks();
    report_and_stop();
  end
endmodule
`default_nettype wire
